// ==== verilog/pifod_top.v ====
`timescale 1ns/1ns
`include "pifod_consts.vh"

////////////////////////////////////////////////////////////////////////////////
// Filter selection, output data and pin readback for 32 I/O lines,
// reached by software over an AXI4-Lite slave port.
module pifod_top (
    // Clock and reset.
    input wire MCLK,
    input wire SYS_RST,
    // AXI4-Lite write address channel.
    input wire [`PIFOD_AW-1:0] S_AXI_AWADDR,
    input wire [2:0] S_AXI_AWPROT,
    input wire S_AXI_AWVALID,
    output reg S_AXI_AWREADY,
    // AXI4-Lite write data channel.
    input wire [31:0] S_AXI_WDATA,
    input wire [3:0] S_AXI_WSTRB,
    input wire S_AXI_WVALID,
    output reg S_AXI_WREADY,
    // AXI4-Lite write response channel.
    output reg [1:0] S_AXI_BRESP,
    output reg S_AXI_BVALID,
    input wire S_AXI_BREADY,
    // AXI4-Lite read address channel.
    input wire [`PIFOD_AW-1:0] S_AXI_ARADDR,
    input wire [2:0] S_AXI_ARPROT,
    input wire S_AXI_ARVALID,
    output reg S_AXI_ARREADY,
    // AXI4-Lite read data channel.
    output reg [31:0] S_AXI_RDATA,
    output reg [1:0] S_AXI_RRESP,
    output reg S_AXI_RVALID,
    input wire S_AXI_RREADY,
    // Per-line state from the ownership and direction logic.
    input wire [`PIFOD_LINES-1:0] LINE_CTRL_OWNED,
    input wire [`PIFOD_LINES-1:0] LINE_OUT_EN,
    // Peripheral drive used while the peripheral owns a line.
    input wire [`PIFOD_LINES-1:0] PERIPH_OUT,
    input wire [`PIFOD_LINES-1:0] PERIPH_OE,
    // Pin pad signals.
    input wire [`PIFOD_LINES-1:0] PIN_IN,
    output reg [`PIFOD_LINES-1:0] PIN_OUT,
    output reg [`PIFOD_LINES-1:0] PIN_OE,
    // Filtered inputs for the peripherals and for change detection.
    output reg [`PIFOD_LINES-1:0] PERIPH_IN,
    output reg [`PIFOD_LINES-1:0] LINE_LEVEL
);

    ////////////////////////////////////////////////////////////////////////////
    // Bus state machine codes.

    // Write side waits for address and data.
    localparam W_IDLE = 1'b0;
    // Write side holds the response.
    localparam W_RESP = 1'b1;
    // Read side waits for an address.
    localparam R_IDLE = 1'b0;
    // Read side holds the data.
    localparam R_DATA = 1'b1;

    ////////////////////////////////////////////////////////////////////////////
    // Declarations.

    // Write state.
    reg w_state;
    // Read state.
    reg r_state;
    // Write address has been taken.
    reg aw_got;
    // Write data have been taken.
    reg w_got;
    // Captured write address.
    reg [`PIFOD_AW-1:0] aw_addr;
    // Captured write data.
    reg [31:0] w_data;
    // Captured write strobes.
    reg [3:0] w_strb;
    // Filter selection per line.
    reg [`PIFOD_LINES-1:0] filt_sel;
    // Stored output data per line.
    reg [`PIFOD_LINES-1:0] out_data;
    // Write data masked by the byte strobes.
    wire [31:0] w_bits;
    // Word-aligned write address.
    wire [`PIFOD_AW-1:0] w_word;
    // Word-aligned read address.
    wire [`PIFOD_AW-1:0] r_word;
    // A write is ready to be performed this cycle.
    wire w_do;
    // Decoded write targets.
    wire w_hit_fen;
    wire w_hit_fdis;
    wire w_hit_set;
    wire w_hit_clr;
    // Any write-only register was addressed.
    wire w_mapped;
    // Filtered level of every line.
    wire [`PIFOD_LINES-1:0] filt_level;
    // Next filter selection and output data.
    reg [`PIFOD_LINES-1:0] next_filt_sel;
    reg [`PIFOD_LINES-1:0] next_out_data;
    // Read data and response chosen for the current read address.
    reg [31:0] next_rdata;
    reg [1:0] next_rresp;

    ////////////////////////////////////////////////////////////////////////////
    // Address and strobe helpers.

    // Bytes without their strobe take no part in a set or clear.
    assign w_bits = w_data & {{8{w_strb[3]}}, {8{w_strb[2]}},
                              {8{w_strb[1]}}, {8{w_strb[0]}}};
    // The two low address bits are ignored, each register is one word.
    assign w_word = {aw_addr[`PIFOD_AW-1:2], 2'b00};
    assign r_word = {S_AXI_ARADDR[`PIFOD_AW-1:2], 2'b00};
    // Both halves of the write have arrived and no response is pending.
    assign w_do = (w_state == W_IDLE) && aw_got && w_got;
    // Write decode.
    assign w_hit_fen = (w_word == `PIFOD_OFF_FILT_EN);
    assign w_hit_fdis = (w_word == `PIFOD_OFF_FILT_DIS);
    assign w_hit_set = (w_word == `PIFOD_OFF_OUT_SET);
    assign w_hit_clr = (w_word == `PIFOD_OFF_OUT_CLR);
    assign w_mapped = w_hit_fen | w_hit_fdis | w_hit_set | w_hit_clr;

    ////////////////////////////////////////////////////////////////////////////
    // Write channel: address and data are taken in either order, each is
    // released once taken, and the response follows both.
    always @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            w_state <= W_IDLE;
            aw_got <= 1'b0;
            w_got <= 1'b0;
            aw_addr <= {`PIFOD_AW{1'b0}};
            w_data <= `PIFOD_ZERO32;
            w_strb <= 4'h0;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= `PIFOD_RESP_OKAY;
        end else begin
            case (w_state)
                W_IDLE: begin
                    // Take the address when offered.
                    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                        aw_addr <= S_AXI_AWADDR;
                        aw_got <= 1'b1;
                        S_AXI_AWREADY <= 1'b0;
                    end else if (!aw_got) begin
                        // Ready whenever no address is held.
                        S_AXI_AWREADY <= 1'b1;
                    end
                    // Take the data when offered.
                    if (S_AXI_WVALID && S_AXI_WREADY) begin
                        w_data <= S_AXI_WDATA;
                        w_strb <= S_AXI_WSTRB;
                        w_got <= 1'b1;
                        S_AXI_WREADY <= 1'b0;
                    end else if (!w_got) begin
                        // Ready whenever no data are held.
                        S_AXI_WREADY <= 1'b1;
                    end
                    // With both held, the write takes effect and is answered.
                    if (w_do) begin
                        S_AXI_BVALID <= 1'b1;
                        if (w_mapped) begin
                            S_AXI_BRESP <= `PIFOD_RESP_OKAY;
                        end else begin
                            // Status registers and holes refuse writes.
                            S_AXI_BRESP <= `PIFOD_RESP_SLVERR;
                        end
                        w_state <= W_RESP;
                    end
                end
                W_RESP: begin
                    // Hold the response until the master takes it.
                    if (S_AXI_BREADY) begin
                        S_AXI_BVALID <= 1'b0;
                        aw_got <= 1'b0;
                        w_got <= 1'b0;
                        S_AXI_AWREADY <= 1'b1;
                        S_AXI_WREADY <= 1'b1;
                        w_state <= W_IDLE;
                    end
                end
                default: begin
                    // Unused code returns to idle.
                    w_state <= W_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register updates. Bit n of each word acts on line n only, ones act and
    // zeros leave the line alone.
    always @* begin
        next_filt_sel = filt_sel;
        next_out_data = out_data;
        if (w_do && w_hit_fen) begin
            // Filter on for every line written as one.
            next_filt_sel = filt_sel | w_bits; // [RULE_01] [RULE_02]
        end
        if (w_do && w_hit_fdis) begin
            // Filter off for every line written as one.
            next_filt_sel = filt_sel & ~w_bits; // [RULE_01] [RULE_03]
        end
        if (w_do && w_hit_set) begin
            // Stored output goes high for lines written as one.
            next_out_data = out_data | w_bits; // [RULE_07]
        end
        if (w_do && w_hit_clr) begin
            // Stored output goes low for lines written as one.
            next_out_data = out_data & ~w_bits; // [RULE_08]
        end
    end

    // The selection changes on the same edge as the write, so the status
    // seen by the very next read is already current.
    always @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            filt_sel <= `PIFOD_RST_FILT; // [RULE_05]
            out_data <= `PIFOD_RST_OUT; // [RULE_10]
        end else begin
            filt_sel <= next_filt_sel; // [RULE_06]
            out_data <= next_out_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-line input path. The filter follows its selection bit alone, so
    // it acts whoever owns the line.
    genvar gi;
    generate
        for (gi = 0; gi < `PIFOD_LINES; gi = gi + 1) begin : g_line
            pifod_line_filter u_filt (
                .clk(MCLK),
                .rst(SYS_RST),
                .pin_raw(PIN_IN[gi]),
                .filt_sel(filt_sel[gi]), // [RULE_04]
                .level(filt_level[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Pin drive and input distribution. The stored value reaches the pad
    // only when the controller owns the line and has its output enabled;
    // on peripheral-owned lines the peripheral drives, and the stored value waits.
    always @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            PIN_OUT <= `PIFOD_ZERO32;
            PIN_OE <= `PIFOD_ZERO32;
            PERIPH_IN <= `PIFOD_ZERO32;
            LINE_LEVEL <= `PIFOD_ZERO32;
        end else begin
            // Owned lines take stored data, others the peripheral's.
            PIN_OUT <= (LINE_CTRL_OWNED & out_data) |
                       (~LINE_CTRL_OWNED & PERIPH_OUT); // [RULE_09] [RULE_14]
            // The output enable is kept but only used on owned lines.
            PIN_OE <= (LINE_CTRL_OWNED & LINE_OUT_EN) |
                      (~LINE_CTRL_OWNED & PERIPH_OE); // [RULE_09] [RULE_15]
            // A peripheral sees the filtered level, and zero when the
            // controller owns its line.
            PERIPH_IN <= ~LINE_CTRL_OWNED & filt_level; // [RULE_05] [RULE_14]
            // Change detection sees the filtered level of every line.
            LINE_LEVEL <= filt_level; // [RULE_05]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read decode. Write-only registers read as zero.
    always @* begin
        next_rdata = `PIFOD_ZERO32;
        next_rresp = `PIFOD_RESP_OKAY;
        case (r_word)
            `PIFOD_OFF_FILT_STAT: begin
                // One for every line with its filter selected.
                next_rdata = filt_sel; // [RULE_05]
            end
            `PIFOD_OFF_OUT_STAT: begin
                // Stored output data, meaningful on owned outputs only.
                next_rdata = out_data; // [RULE_10] [RULE_11]
            end
            `PIFOD_OFF_PIN_STAT: begin
                // Pad level after synchroniser and filter, any owner.
                next_rdata = filt_level; // [RULE_12] [RULE_13]
            end
            `PIFOD_OFF_FILT_EN,
            `PIFOD_OFF_FILT_DIS,
            `PIFOD_OFF_OUT_SET,
            `PIFOD_OFF_OUT_CLR: begin
                // Write-only words answer with zero.
                next_rdata = `PIFOD_ZERO32;
            end
            default: begin
                // Holes in the map are refused.
                next_rresp = `PIFOD_RESP_SLVERR;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read channel: one read at a time, data captured when the address is
    // taken and held until the master accepts it.
    always @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            r_state <= R_IDLE;
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= `PIFOD_ZERO32;
            S_AXI_RRESP <= `PIFOD_RESP_OKAY;
        end else begin
            case (r_state)
                R_IDLE: begin
                    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
                        // Address taken, data go out next cycle.
                        S_AXI_ARREADY <= 1'b0;
                        S_AXI_RVALID <= 1'b1;
                        S_AXI_RDATA <= next_rdata;
                        S_AXI_RRESP <= next_rresp;
                        r_state <= R_DATA;
                    end else begin
                        // Ready while idle.
                        S_AXI_ARREADY <= 1'b1;
                    end
                end
                R_DATA: begin
                    // Hold data until accepted.
                    if (S_AXI_RREADY) begin
                        S_AXI_RVALID <= 1'b0;
                        S_AXI_ARREADY <= 1'b1;
                        r_state <= R_IDLE;
                    end
                end
                default: begin
                    // Unused code returns to idle.
                    r_state <= R_IDLE;
                end
            endcase
        end
    end

endmodule // pifod_top

// ==== verilog/pifod_consts.vh ====
// Function
// RULE_01: Bit n of every register is line n.
// RULE_02: Filter-enable ones switch that line's filter on.
// RULE_03: Filter-disable ones switch that line's filter off.
// RULE_04: Filter acts regardless of line ownership.
// RULE_05: Filter feeds both paths; status resets zero.
// RULE_06: Filter status follows enable/disable writes at once.
// RULE_07: Set-output ones make stored output one.
// RULE_08: Clear-output ones make stored output zero.
// RULE_09: Stored value drives pin only when owned, enabled.
// RULE_10: Output status returns stored values; resets zero.
// RULE_11: Output status matters only for owned outputs.
// RULE_12: Pin status returns real pin levels. Code returns the level after synchroniser and selected filter.
// RULE_13: Pin readback valid for any ownership, direction.
// RULE_14: Control-enable set means controller owns line.
// RULE_15: Output-enable state kept even under peripheral.
// RULE_16: Filter removes pulses under one clock period.
// RULE_17: Pins pass two synchroniser flops first.
`ifndef PIFOD_CONSTS_VH
`define PIFOD_CONSTS_VH

// Number of lines and register width.
`define PIFOD_LINES 32
// Bus address width in bits.
`define PIFOD_AW 8

// Register byte offsets.
`define PIFOD_OFF_FILT_EN 8'h20
`define PIFOD_OFF_FILT_DIS 8'h24
`define PIFOD_OFF_FILT_STAT 8'h28
`define PIFOD_OFF_OUT_SET 8'h30
`define PIFOD_OFF_OUT_CLR 8'h34
`define PIFOD_OFF_OUT_STAT 8'h38
`define PIFOD_OFF_PIN_STAT 8'h3C

// Reset values.
`define PIFOD_RST_FILT 32'h00000000
`define PIFOD_RST_OUT 32'h00000000
`define PIFOD_RST_PIN 32'h00000000
`define PIFOD_ZERO32 32'h00000000

// Bus response codes.
`define PIFOD_RESP_OKAY 2'h0
`define PIFOD_RESP_SLVERR 2'h2

`endif

// ==== verilog/pifod_line_filter.v ====
`timescale 1ns/1ns
`include "pifod_consts.vh"

////////////////////////////////////////////////////////////////////////////////
// One line: two-flop synchroniser, a third stage for the stability check,
// and a selectable glitch filter. The result comes straight from a flop.
module pifod_line_filter (
    // Clock and reset.
    input wire clk,
    input wire rst,
    // Raw pin level and filter selection.
    input wire pin_raw,
    input wire filt_sel,
    // Filtered, synchronised level.
    output reg level
);

    // First synchroniser stage, read only by the second.
    reg sync_a;
    // Second synchroniser stage.
    reg sync_b;
    // Delayed copy of the second stage for the stability check.
    reg sync_c;
    // Value the filter would settle to next.
    reg next_level;

    ////////////////////////////////////////////////////////////////////////////
    // The synchroniser chain samples the pin every clock.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            sync_c <= 1'b0;
        end else begin
            sync_a <= pin_raw; // [RULE_17]
            sync_b <= sync_a; // [RULE_17]
            sync_c <= sync_b;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // A filtered line only moves after two equal samples, so a pulse that
    // covers a single sample at most never reaches the output.
    always @* begin
        next_level = level;
        if (!filt_sel) begin
            // Filter off: the synchronised level passes straight through.
            next_level = sync_b;
        end else if (sync_b == sync_c) begin
            // Filter on and the level held for two samples.
            next_level = sync_c; // [RULE_16]
        end
    end

    // The output flop holds the accepted level.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            level <= 1'b0;
        end else begin
            level <= next_level;
        end
    end

endmodule // pifod_line_filter

// ==== verification/pifod_pin_model.sv ====
`timescale 1ns/1ns
////////////////////////////////////////
// Outside world at the pads: the controller wins where it drives, other
// devices drive where enabled, and a floating pad flips every cycle.
module pifod_pin_model (
    // Clock for the floating pattern.
    input wire logic clk,
    // Pad drive from the controller.
    input wire logic [31:0] pin_out,
    input wire logic [31:0] pin_oe,
    // Drive from outside devices.
    input wire logic [31:0] ext_val,
    input wire logic [31:0] ext_oe,
    // Level seen on each pad.
    output logic [31:0] pin_level
);
    // Floating pads never hold a steady value.
    logic [31:0] float_pat = 32'h55555555;

    // Flip the floating pattern each cycle.
    always @(posedge clk) begin
        float_pat <= ~float_pat;
    end

    // Resolve each pad from all drivers.
    assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_oe & ext_val)
        | (~pin_oe & ~ext_oe & float_pat);
endmodule // pifod_pin_model

// ==== verification/pifod_assertions.sv ====
`timescale 1ns/1ns
////////////////////////////////////////
// Bus handshake and pad mux checks on the top ports.
module pifod_checker (
    // Clock and reset.
    input wire logic MCLK,
    input wire logic SYS_RST,
    // Bus handshakes.
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_WVALID,
    input wire logic S_AXI_WREADY,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // Line state and pads.
    input wire logic [31:0] LINE_CTRL_OWNED,
    input wire logic [31:0] LINE_OUT_EN,
    input wire logic [31:0] PERIPH_OUT,
    input wire logic [31:0] PERIPH_OE,
    input wire logic [31:0] PIN_OUT,
    input wire logic [31:0] PIN_OE
);
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (SYS_RST);
    // High from the second edge after reset, so $past sees live inputs.
    logic up;

    // Track the first edge after reset.
    always @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            up <= 1'b0;
        end else begin
            up <= 1'b1;
        end
    end

    a_b_holds: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
        else $error("write response dropped early");
    a_r_holds: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID)
        else $error("read data dropped early");
    a_aw_blocked: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
        else $error("write taken while response pending");
    a_ar_blocked: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
        else $error("read taken while data pending");
    a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |-> ##[1:2] S_AXI_RVALID)
        else $error("read not answered");
    a_write_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID
        && S_AXI_WREADY |-> ##[1:2] S_AXI_BVALID)
        else $error("write not answered");
    a_oe_map: assert property (up |-> PIN_OE == $past(LINE_CTRL_OWNED & LINE_OUT_EN
        | ~LINE_CTRL_OWNED & PERIPH_OE))
        else $error("pad enable wrong");
    a_periph_drive: assert property (up |-> (PIN_OUT & $past(~LINE_CTRL_OWNED & PERIPH_OE))
        == $past(~LINE_CTRL_OWNED & PERIPH_OE & PERIPH_OUT))
        else $error("peripheral pad value wrong");

    c_write: cover property (S_AXI_BVALID && S_AXI_BREADY);
    c_read: cover property (S_AXI_RVALID && S_AXI_RREADY);
    c_pad: cover property (PIN_OE != 32'h00000000);
endmodule // pifod_checker

bind pifod_top pifod_checker chk_u (.MCLK, .SYS_RST, .S_AXI_AWVALID, .S_AXI_AWREADY,
    .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARVALID,
    .S_AXI_ARREADY, .S_AXI_RVALID, .S_AXI_RREADY, .LINE_CTRL_OWNED, .LINE_OUT_EN,
    .PERIPH_OUT, .PERIPH_OE, .PIN_OUT, .PIN_OE);

// ==== verification/test_parallel_io_filter_and_output_data.sv ====
`timescale 1ns/1ns
`include "pifod_consts.vh"
////////////////////////////////////////
// Register, pad and filter tests driven over the bus.
module test_parallel_io_filter_and_output_data;
    localparam logic [1:0] OK = `PIFOD_RESP_OKAY;
    localparam logic [1:0] ER = `PIFOD_RESP_SLVERR;
    // Clock, reset and bus signals.
    logic MCLK, SYS_RST;
    logic [7:0] S_AXI_AWADDR, S_AXI_ARADDR;
    logic [2:0] S_AXI_AWPROT, S_AXI_ARPROT;
    logic [3:0] S_AXI_WSTRB;
    logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
    logic S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
    logic S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY;
    logic S_AXI_RVALID, S_AXI_RREADY;
    // Line state, peripheral drive, pads and outside drivers.
    logic [31:0] LINE_CTRL_OWNED, LINE_OUT_EN, PERIPH_OUT, PERIPH_OE;
    logic [31:0] PIN_IN, PIN_OUT, PIN_OE, PERIPH_IN, LINE_LEVEL;
    logic [31:0] ext_val, ext_oe, seen;
    int n_mismatch = 0;
    int num_checks = 0;
    int cycles = 0;

    pifod_top dut_u (.MCLK, .SYS_RST, .S_AXI_AWADDR, .S_AXI_AWPROT, .S_AXI_AWVALID,
        .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY,
        .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARPROT,
        .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID,
        .S_AXI_RREADY, .LINE_CTRL_OWNED, .LINE_OUT_EN, .PERIPH_OUT, .PERIPH_OE,
        .PIN_IN, .PIN_OUT, .PIN_OE, .PERIPH_IN, .LINE_LEVEL);
    pifod_pin_model pins_u (.clk(MCLK), .pin_out(PIN_OUT), .pin_oe(PIN_OE),
        .ext_val(ext_val), .ext_oe(ext_oe), .pin_level(PIN_IN));

    // 8 ns clock.
    always #4 MCLK = ~MCLK;

    // Cut a hang short; the whole run needs well under a thousand cycles.
    always @(posedge MCLK) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_mismatch = n_mismatch + 1;
            tally_and_finish();
        end
    end

    ////////////////////////////////////////
    // Compare one value and count it.
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // One bus write; each channel is released when taken.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        bit aw, w, b;
        aw = 0;
        w = 0;
        b = 0;
        S_AXI_AWADDR <= a;
        S_AXI_WDATA <= d;
        S_AXI_WSTRB <= s;
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WVALID <= 1'b1;
        S_AXI_BREADY <= 1'b1;
        while (!b) begin
            @(posedge MCLK);
            if (!aw && S_AXI_AWREADY) begin
                aw = 1;
                S_AXI_AWVALID <= 1'b0;
            end
            if (!w && S_AXI_WREADY) begin
                w = 1;
                S_AXI_WVALID <= 1'b0;
            end
            b = S_AXI_BVALID;
        end
        chk("write response", {30'h0, er}, {30'h0, S_AXI_BRESP});
    endtask

    // One bus read, compared with the expected word and response.
    task automatic rdr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        bit r;
        r = 0;
        S_AXI_ARADDR <= a;
        S_AXI_ARVALID <= 1'b1;
        S_AXI_RREADY <= 1'b1;
        while (!r) begin
            @(posedge MCLK);
            if (S_AXI_ARREADY) begin
                S_AXI_ARVALID <= 1'b0;
            end
            r = S_AXI_RVALID;
        end
        chk($sformatf("read data at %h", a), ed, S_AXI_RDATA);
        chk("read response", {30'h0, er}, {30'h0, S_AXI_RRESP});
    endtask

    // Pad enables, and pad values where enabled.
    task automatic pads(input logic [31:0] eoe, input logic [31:0] eout);
        chk("pad enable", eoe, PIN_OE);
        chk("pad value", eout, PIN_OUT & eoe);
    endtask

    // Gather any high level on the masked lines over eight cycles.
    task automatic watch(input logic [31:0] m, input logic [31:0] e);
        seen = 32'h0;
        repeat (8) begin
            @(posedge MCLK);
            seen = seen | (LINE_LEVEL & m);
        end
        chk("pulse seen on line level", e, seen);
    endtask

    // Print the counts and the verdict, then stop.
    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    ////////////////////////////////////////
    // Main sequence.
    initial begin
        MCLK = 1'b0;
        SYS_RST = 1'b1;
        {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_AWPROT, S_AXI_ARPROT} = '0;
        {S_AXI_WDATA, S_AXI_WSTRB, S_AXI_AWVALID, S_AXI_WVALID} = '0;
        {S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = '0;
        {LINE_CTRL_OWNED, LINE_OUT_EN, PERIPH_OUT, PERIPH_OE, ext_val} = '0;
        ext_oe = 32'hFFFFFFFF;
        repeat (6) @(posedge MCLK);
        SYS_RST <= 1'b0;
        repeat (2) @(posedge MCLK);
        rdr(`PIFOD_OFF_FILT_STAT, 32'h0, OK);
        rdr(`PIFOD_OFF_OUT_STAT, 32'h0, OK);
        rdr(`PIFOD_OFF_PIN_STAT, 32'h0, OK);
        wr(`PIFOD_OFF_FILT_EN, 32'hF0F000FF, 4'hF, OK);
        rdr(`PIFOD_OFF_FILT_STAT, 32'hF0F000FF, OK);
        wr(`PIFOD_OFF_FILT_DIS, 32'h3030000F, 4'hF, OK);
        rdr(`PIFOD_OFF_FILT_STAT, 32'hC0C000F0, OK);
        wr(`PIFOD_OFF_FILT_EN, 32'hFFFFFFFF, 4'h2, OK);
        rdr(`PIFOD_OFF_FILT_STAT, 32'hC0C0FFF0, OK);
        wr(`PIFOD_OFF_OUT_SET, 32'hA5A55A5A, 4'hF, OK);
        wr(`PIFOD_OFF_OUT_CLR, 32'h0000FFFF, 4'hF, OK);
        rdr(`PIFOD_OFF_OUT_STAT, 32'hA5A50000, OK);
        wr(`PIFOD_OFF_OUT_STAT, 32'hFFFFFFFF, 4'hF, ER);
        rdr(`PIFOD_OFF_OUT_STAT, 32'hA5A50000, OK);
        rdr(8'h00, 32'h0, ER);
        rdr(`PIFOD_OFF_FILT_EN, 32'h0, OK);
        // Mixed ownership and direction; outside devices drive the rest.
        LINE_CTRL_OWNED <= 32'hFFFF0000;
        LINE_OUT_EN <= 32'hFF00FF00;
        PERIPH_OE <= 32'h000000FF;
        PERIPH_OUT <= 32'h000000AA;
        ext_oe <= 32'h00FFFF00;
        repeat (4) @(posedge MCLK);
        pads(32'hFF0000FF, 32'hA50000AA);
        repeat (8) @(posedge MCLK);
        rdr(`PIFOD_OFF_PIN_STAT, 32'hA50000AA, OK);
        chk("peripheral input", 32'h000000AA, PERIPH_IN);
        // Stored output takes effect once the line is enabled.
        LINE_OUT_EN <= 32'hFFFFFF00;
        ext_oe <= 32'h0000FF00;
        repeat (4) @(posedge MCLK);
        pads(32'hFFFF00FF, 32'hA5A500AA);
        // One-cycle pulse on filtered peripheral lines must vanish.
        ext_val <= 32'h0000FF00;
        @(posedge MCLK);
        ext_val <= 32'h0;
        watch(32'h0000FF00, 32'h0);
        wr(`PIFOD_OFF_FILT_DIS, 32'h0000FF00, 4'hF, OK);
        ext_val <= 32'h00000F00;
        repeat (8) @(posedge MCLK);
        rdr(`PIFOD_OFF_PIN_STAT, 32'hA5A50FAA, OK);
        // The same pulse passes once the filter is off.
        ext_val <= 32'h0000FF00;
        @(posedge MCLK);
        ext_val <= 32'h00000F00;
        watch(32'h0000F000, 32'h0000F000);
        tally_and_finish();
    end
endmodule // test_parallel_io_filter_and_output_data
